// ==== aps_pkg.sv ====
// shared constants for the adc power-mode sequencer, device and host ends
// assumes a single 100 MHz reference clock in both ends
package aps_pkg;
    // reference clock
    localparam int CLK_PERIOD_NS   = 10;
    // serial frame edge counts (serial-clock falling edges)
    localparam int EDGE_W          = 5;
    localparam logic [4:0] PD_WIN_LO    = 5'h02;
    localparam logic [4:0] PD_WIN_HI    = 5'h0A;
    localparam logic [4:0] TRACK_EDGES  = 5'h0D;
    localparam logic [4:0] FULL_EDGES   = 5'h10;
    localparam logic [4:0] LAST_EDGE    = 5'h0F;
    localparam logic [4:0] PD_BURST     = 5'h08;
    // frame layout: leading zeros, result, trailing zeros
    localparam int FRAME_W         = 16;
    localparam int LEAD_ZEROS      = 4;
    localparam int DATA_W_DEF      = 12;
    localparam int DATA_W_MAX      = 12;
    // power-up time, typical
    localparam int PWRUP_NS        = 1000;
    localparam int PWRUP_CYC       = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // fastest serial clock the device accepts
    localparam int SCLK_MAX_MHZ    = 20;
    localparam int SCLK_MIN_HALF   = (500 / SCLK_MAX_MHZ + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // host serial-clock half period, 80 ns period by default
    localparam int HALF_CYC_DEF    = 4;
    // host needs this many cycles per half so the synced data bit has settled
    localparam int HALF_CYC_MIN    = 4;
    // quiet interval after the data line releases
    localparam int QUIET_NS        = 50;
    localparam int QUIET_CYC       = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // device power states
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_PDOWN  = 3'b010,
        ST_WAKE   = 3'b100
    } aps_pwr_t;
    // host sequencer states
    typedef enum logic [3:0] {
        H_IDLE  = 4'b0001,
        H_SETUP = 4'b0010,
        H_RUN   = 4'b0100,
        H_QUIET = 4'b1000
    } aps_host_t;
endpackage

// ==== aps_link_if.sv ====
// serial link between the converter and its host serial master
// assumes the bench joins both ends to one instance; no clock of its own
`timescale 1ns/100ps
interface aps_link_if;
    logic cs_n;
    logic sclk;
    logic serial_result_out;
    logic serial_result_oe;
    logic serial_result_line;
    // released line reads low, as a weak pull-down would leave it
    assign serial_result_line = serial_result_oe ? serial_result_out : 1'b0;
    modport device (
        input  cs_n,
        input  sclk,
        output serial_result_out,
        output serial_result_oe
    );
    modport host (
        output cs_n,
        output sclk,
        input  serial_result_line
    );
endinterface

// ==== aps_dev.sv ====
// device end: power-mode sequencer of a serial-output converter
// assumes chip select and serial clock come from another domain and are
// sampled here at 100 MHz; the result word arrives on the same clock
`timescale 1ns/100ps
// Notes on behaviour
// [R1] rise in edges 2..9 powers down, releases data
// [R2] rise before edge 2 keeps normal mode
// [R3] select fall in power-down starts waking
// [R4] wake rise before edge 10 returns to power-down
// [R5] wake frame fully powers; next frame valid
// [R6] one dummy frame covers power-up time
// [R7] host waits quiet interval before next select
// [R8] wake: track resumes after first clock edge
// [R9] host may end dummy early after edge 10
// [R10] supply start either mode, already tracking; a power-down start holds from the first cycle after reset
// [R11] host runs one dummy frame after supply
// [R12] host may hold power-down with short frame
// [R13] supply power-up time equals wake time
// [R14] host uses power-down only at low rates
// [R15] normal: rise at edge 10+ stays powered
// [R16] sixteen clocks per frame; release at 16th
// [R17] count falling edges per frame, judge at rise
module aps_dev #(
    parameter int DATA_W    = aps_pkg::DATA_W_DEF,
    parameter int PWRUP_CYC = aps_pkg::PWRUP_CYC
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    aps_link_if.device             lnk,
    input  wire logic [DATA_W-1:0] i_sample,
    input  wire logic              i_start_pd,
    output logic                   o_power_down,
    output logic                   o_fully_up,
    output logic                   o_tracking,
    output logic                   o_valid_frame
);
    localparam int TRAIL = aps_pkg::FRAME_W - aps_pkg::LEAD_ZEROS - DATA_W;

    // refuse widths the frame cannot carry
    generate
        if (DATA_W < 1 || DATA_W > aps_pkg::DATA_W_MAX) begin : g_bad_w
            $error("aps_dev: DATA_W out of range");
        end
        if (PWRUP_CYC < 1 || PWRUP_CYC > 65535) begin : g_bad_p
            $error("aps_dev: PWRUP_CYC out of range");
        end
    endgenerate

    logic [2:0]                       cs_sync_r;
    logic [2:0]                       sclk_sync_r;
    logic                             frame_r;
    logic [aps_pkg::EDGE_W-1:0]       edge_cnt_r;
    aps_pkg::aps_pwr_t                state_r;
    logic                             strap_done_r;
    logic [15:0]                      pwr_cnt_r;
    logic                             fully_up_r;
    logic [aps_pkg::FRAME_W-1:0]      shift_r;
    logic                             sdo_r;
    logic                             sdo_oe_r;
    logic                             track_r;
    logic                             valid_r;
    logic                             pd_out_r;
    logic                             cs_fall;
    logic                             cs_rise;
    logic                             sclk_fall;
    logic                             sclk_rise;
    logic                             in_window;
    logic                             enter_pd;
    logic                             wake_done;
    logic [aps_pkg::FRAME_W-1:0]      frame_word;

    // two-flop synchronisers; bit 2 only serves the edge detectors
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cs_sync_r   <= 3'h7;
            sclk_sync_r <= 3'h7;
        end else begin
            cs_sync_r   <= {cs_sync_r[1:0], lnk.cs_n};
            sclk_sync_r <= {sclk_sync_r[1:0], lnk.sclk};
        end
    end

    // edges seen on the synchronised pins
    assign cs_fall   = cs_sync_r[2] & ~cs_sync_r[1];
    assign cs_rise   = ~cs_sync_r[2] & cs_sync_r[1];
    assign sclk_fall = frame_r & sclk_sync_r[2] & ~sclk_sync_r[1];
    assign sclk_rise = frame_r & ~sclk_sync_r[2] & sclk_sync_r[1];

    // power-down entry window on the count held at the select rise
    assign in_window = (edge_cnt_r >= aps_pkg::PD_WIN_LO) &&
                       (edge_cnt_r < aps_pkg::PD_WIN_HI);

    // every path into power-down, strap included
    assign enter_pd = (!strap_done_r && i_start_pd) ||
                      (strap_done_r && state_r == aps_pkg::ST_NORMAL &&
                       frame_r && cs_rise && in_window) ||                // [R1] [R2]
                      (strap_done_r && state_r == aps_pkg::ST_WAKE &&
                       cs_rise && edge_cnt_r < aps_pkg::PD_WIN_HI);       // [R4]

    // a wake frame that runs its full sixteen clocks ends power-up
    assign wake_done = state_r == aps_pkg::ST_WAKE && sclk_fall &&
                       edge_cnt_r == aps_pkg::LAST_EDGE;                  // [R5]

    // result word, left aligned behind the leading zeros
    assign frame_word = (TRAIL > 0) ?
        aps_pkg::FRAME_W'({{aps_pkg::LEAD_ZEROS{1'b0}}, i_sample} << TRAIL) :
        aps_pkg::FRAME_W'({{aps_pkg::LEAD_ZEROS{1'b0}}, i_sample});

    // frame window between select fall and rise
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            frame_r <= 1'b0;
        end else if (cs_fall) begin
            frame_r <= 1'b1;
        end else if (cs_rise) begin
            frame_r <= 1'b0;
        end
    end

    // falling-edge count per frame, saturates at sixteen
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            edge_cnt_r <= '0;
        end else if (cs_fall) begin
            edge_cnt_r <= '0;                                             // [R17]
        end else if (sclk_fall && edge_cnt_r != aps_pkg::FULL_EDGES) begin
            edge_cnt_r <= edge_cnt_r + 5'h01;                             // [R17]
        end
    end

    // supply-start mode is caught in the first cycle after reset release
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            strap_done_r <= 1'b0;
        end else begin
            strap_done_r <= 1'b1;                                         // [R10]
        end
    end

    // power state, judged at the select edges and at the supply-start strap
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= aps_pkg::ST_NORMAL;
        end else if (enter_pd) begin
            state_r <= aps_pkg::ST_PDOWN;                                 // [R1] [R4] [R10]
        end else if (strap_done_r) begin
            case (state_r)
                aps_pkg::ST_NORMAL: begin
                    state_r <= aps_pkg::ST_NORMAL;                        // [R2] [R15]
                end
                aps_pkg::ST_PDOWN: begin
                    if (cs_fall) begin
                        state_r <= aps_pkg::ST_WAKE;                      // [R3]
                    end
                end
                aps_pkg::ST_WAKE: begin
                    // past the tenth edge the wake sticks
                    if (cs_rise) begin
                        state_r <= aps_pkg::ST_NORMAL;                    // [R9]
                    end
                end
                default: begin
                    state_r <= aps_pkg::ST_NORMAL;
                end
            endcase
        end
    end

    // power-up timer runs from reset and from each wake; one microsecond
    // can outlast a dummy frame cut short after edge 10; a full wake frame ends it at its 16th fall, so one full frame suffices
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pwr_cnt_r  <= '0;
            fully_up_r <= 1'b0;
        end else if (enter_pd || state_r == aps_pkg::ST_PDOWN) begin
            pwr_cnt_r  <= '0;
            fully_up_r <= 1'b0;
        end else if (!fully_up_r) begin
            if (wake_done || pwr_cnt_r == 16'(PWRUP_CYC - 1)) begin
                fully_up_r <= 1'b1;                                       // [R5] [R6] [R13]
            end
            pwr_cnt_r <= pwr_cnt_r + 16'h0001;
        end
    end

    // data line: driven from select fall, released at the 16th fall or
    // at an early select rise, whichever comes first
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            shift_r  <= '0;
            sdo_r    <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else if (cs_fall) begin
            shift_r  <= {frame_word[aps_pkg::FRAME_W-2:0], 1'b0};
            sdo_r    <= frame_word[aps_pkg::FRAME_W-1];
            sdo_oe_r <= 1'b1;
        end else if (cs_rise) begin
            sdo_oe_r <= 1'b0;                                             // [R1] [R15]
        end else if (sclk_fall) begin
            sdo_r   <= shift_r[aps_pkg::FRAME_W-1];
            shift_r <= {shift_r[aps_pkg::FRAME_W-2:0], 1'b0};
            if (edge_cnt_r == aps_pkg::LAST_EDGE) begin
                sdo_oe_r <= 1'b0;                                         // [R16]
            end
        end
    end

    // track-and-hold: holds from select fall and through power-down
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            track_r <= 1'b1;                                              // [R10]
        end else if (enter_pd) begin
            track_r <= 1'b0;
        end else if (cs_fall) begin
            track_r <= 1'b0;
        end else if (state_r == aps_pkg::ST_WAKE && (sclk_fall || sclk_rise)) begin
            track_r <= 1'b1;                                              // [R8]
        end else if (sclk_rise && edge_cnt_r >= aps_pkg::TRACK_EDGES) begin
            track_r <= 1'b1;
        end else if (cs_rise && state_r == aps_pkg::ST_NORMAL) begin
            // terminated conversion goes back to acquiring
            track_r <= 1'b1;
        end
    end

    // a frame carries a valid result only once fully powered
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            valid_r  <= 1'b0;
            pd_out_r <= 1'b0;
        end else begin
            if (cs_fall) begin
                valid_r <= state_r == aps_pkg::ST_NORMAL && fully_up_r;   // [R5]
            end
            pd_out_r <= state_r == aps_pkg::ST_PDOWN;
        end
    end

    assign lnk.serial_result_out = sdo_r;
    assign lnk.serial_result_oe  = sdo_oe_r;
    assign o_power_down          = pd_out_r;
    assign o_fully_up            = fully_up_r;
    assign o_tracking            = track_r;
    assign o_valid_frame         = valid_r;
endmodule

// ==== aps_host.sv ====
// host end: serial master that frames the converter with a set number of
// clock falls; runs one dummy frame by itself after reset
// assumes the data line arrives from another domain and is synchronised here
`timescale 1ns/100ps
module aps_host #(
    parameter int HALF_CYC  = aps_pkg::HALF_CYC_DEF,
    parameter int QUIET_CYC = aps_pkg::QUIET_CYC
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    aps_link_if.host         lnk,
    input  wire logic        i_start,
    input  wire logic [4:0]  i_edges,
    input  wire logic        i_keep_pd,
    output logic             o_ready,
    output logic             o_done,
    output logic [15:0]      o_data
);
    // the device drops the data line up to four cycles after select rise,
    // so the quiet interval is counted from there, not from the rise itself
    localparam int REL_CYC = 4;

    // refuse clock rates above the device limit or too fast to sample
    generate
        if (HALF_CYC < aps_pkg::HALF_CYC_MIN || HALF_CYC < aps_pkg::SCLK_MIN_HALF ||
            HALF_CYC > 255) begin : g_bad_half
            $error("aps_host: HALF_CYC out of range");
        end
        if (QUIET_CYC < 1 || QUIET_CYC > 255 - REL_CYC) begin : g_bad_quiet
            $error("aps_host: QUIET_CYC out of range");
        end
    endgenerate

    aps_pkg::aps_host_t state_r;
    logic [7:0]  div_r;
    logic        tick;
    logic [7:0]  quiet_r;
    logic [4:0]  len_r;
    logic [4:0]  fall_cnt_r;
    logic        cs_n_r;
    logic        sclk_r;
    logic        init_r;
    logic [1:0]  sdo_sync_r;
    logic [15:0] data_r;
    logic        ready_r;
    logic        done_r;
    logic [4:0]  req_len;

    // half-period enable from a free divider
    assign tick = div_r == 8'(HALF_CYC - 1);
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // data line synchroniser
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sdo_sync_r <= '0;
        end else begin
            sdo_sync_r <= {sdo_sync_r[0], lnk.serial_result_line};
        end
    end

    // frame length: zero or above sixteen means a full frame; a short
    // frame between 2 and 9 puts the part down, worth it at low rates only
    assign req_len = (i_edges == 5'h00 || i_edges > aps_pkg::FULL_EDGES) ?
                     aps_pkg::FULL_EDGES : i_edges;                       // [R9] [R14]

    // frame sequencer
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r    <= aps_pkg::H_IDLE;
            cs_n_r     <= 1'b1;
            sclk_r     <= 1'b1;
            len_r      <= aps_pkg::FULL_EDGES;
            fall_cnt_r <= '0;
            quiet_r    <= '0;
            init_r     <= 1'b1;
            data_r     <= '0;
            ready_r    <= 1'b0;
            done_r     <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                aps_pkg::H_IDLE: begin
                    // the power-up dummy needs no wait before it
                    if (init_r) begin
                        len_r   <= i_keep_pd ? aps_pkg::PD_BURST
                                             : aps_pkg::FULL_EDGES;       // [R11] [R12]
                        init_r  <= 1'b0;
                        ready_r <= 1'b0;
                        cs_n_r  <= 1'b0;
                        state_r <= aps_pkg::H_SETUP;
                    end else if (i_start && ready_r) begin
                        len_r   <= req_len;
                        ready_r <= 1'b0;
                        cs_n_r  <= 1'b0;
                        state_r <= aps_pkg::H_SETUP;
                    end else begin
                        ready_r <= 1'b1;
                    end
                    fall_cnt_r <= '0;
                end
                aps_pkg::H_SETUP: begin
                    if (tick) begin
                        state_r <= aps_pkg::H_RUN;
                    end
                end
                aps_pkg::H_RUN: begin
                    if (tick) begin
                        if (!sclk_r) begin
                            sclk_r <= 1'b1;
                        end else if (fall_cnt_r == len_r) begin
                            cs_n_r  <= 1'b1;
                            quiet_r <= '0;
                            state_r <= aps_pkg::H_QUIET;
                        end else begin
                            // bit launched a full period ago has settled
                            sclk_r     <= 1'b0;
                            fall_cnt_r <= fall_cnt_r + 5'h01;
                            data_r     <= {data_r[14:0], sdo_sync_r[1]};
                        end
                    end
                end
                aps_pkg::H_QUIET: begin
                    // wait out the device's release latency, then the quiet interval
                    if (quiet_r == 8'(QUIET_CYC + REL_CYC - 1)) begin
                        done_r  <= 1'b1;
                        state_r <= aps_pkg::H_IDLE;                       // [R7]
                    end else begin
                        quiet_r <= quiet_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= aps_pkg::H_IDLE;
                    cs_n_r  <= 1'b1;
                    sclk_r  <= 1'b1;
                end
            endcase
        end
    end

    assign lnk.cs_n = cs_n_r;
    assign lnk.sclk = sclk_r;
    assign o_ready  = ready_r;
    assign o_done   = done_r;
    assign o_data   = data_r;
endmodule

// ==== aps_link_assertions.sv ====
// concurrent checks on the serial link between converter and host
// assumes plain link signals, the 100 MHz reference clock and its reset
`timescale 1ns/100ps
module aps_link_assertions (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic serial_result_out,
    input  wire logic serial_result_oe,
    input  wire logic serial_result_line
);
    logic [4:0] fall_cnt_r;
    logic       sclk_q_r;
    logic       cs_q_r;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // raw clock falls since select fall; kept after the frame so trailing bits still see it
    always_ff @(posedge i_ref_clk) begin
        sclk_q_r <= sclk;
        cs_q_r   <= cs_n;
        if (i_rst) begin
            fall_cnt_r <= 5'h00;
        end else if (cs_q_r && !cs_n) begin
            fall_cnt_r <= 5'h00;
        end else if (!cs_n && sclk_q_r && !sclk && fall_cnt_r != 5'h1F) begin
            fall_cnt_r <= fall_cnt_r + 5'h01;
        end
    end
    sequence s_sel_fall;
        $fell(cs_n);
    endsequence
    sequence s_idle6;
        cs_n [*6];
    endsequence
    sequence s_bit_hold;
        $stable(serial_result_out) [*2];
    endsequence
    a_drive_on_select: assert property (s_sel_fall |-> ##[1:6] serial_result_oe)
        else $error("data line not driven after select fall");
    a_release_on_rise: assert property ($rose(cs_n) |-> ##[1:6] !serial_result_oe)
        else $error("data line still driven after select rise");
    a_idle_released: assert property (s_idle6 |-> !serial_result_oe)
        else $error("data line driven while deselected");
    a_release_at_16: assert property ($rose(fall_cnt_r == 5'h10) |-> ##[1:5] !serial_result_oe)
        else $error("data line not released at sixteenth fall");
    a_lead_zeros: assert property ((serial_result_oe && fall_cnt_r <= 5'h03) |-> (!serial_result_out && !serial_result_line))
        else $error("leading zero missing");
    a_bit_stable: assert property (($rose(sclk) && !cs_n) |-> ##1 s_bit_hold)
        else $error("data bit moved while clock high");
    a_frame_cap: assert property ($rose(cs_n) |-> fall_cnt_r <= 5'h10)
        else $error("more than sixteen falls in a frame");
    a_quiet_gap: assert property ($fell(serial_result_oe) |=> !$fell(cs_n) [*4])
        else $error("select fell inside quiet interval");
    a_sclk_idle: assert property (cs_n |-> sclk)
        else $error("serial clock low outside a frame");
endmodule

// ==== test_adc_power_mode_sequencer.sv ====
// self-checking bench: host end and device end joined by one link
// assumes default design parameters; link clock made by the host divider
`timescale 1ns/100ps
module test_adc_power_mode_sequencer;
    typedef struct packed {
        logic [4:0] edges;
        logic       exp_pd;
        logic       chk_valid;
        logic       exp_valid;
        logic       chk_data;
        logic       chk_up;
    } aps_row_t;
    localparam int       LIMIT = 20000;
    localparam int       PWRUP = aps_pkg::PWRUP_CYC;
    // falls per frame, power-down after, valid flag, data and fully-up checks
    localparam aps_row_t ROWS [9] = '{
        '{5'h14, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},  // over-long request runs full frame
        '{5'h01, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},  // glitch stays normal
        '{5'h02, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0},  // lowest entry count
        '{5'h08, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},  // eight-clock burst keeps asleep
        '{5'h10, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},  // dummy wake frame
        '{5'h09, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0},  // highest entry count
        '{5'h0A, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0},  // short wake frame
        '{5'h0C, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},  // early end stays up
        '{5'h00, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1}   // zero asks full frame, valid
    };
    logic        i_ref_clk;
    logic        i_rst;
    logic [11:0] i_sample;
    logic        i_start_pd;
    logic        i_start;
    logic [4:0]  i_edges;
    logic        i_keep_pd;
    logic        power_down;
    logic        fully_up;
    logic        tracking;
    logic        valid_frame;
    logic        ready;
    logic        done;
    logic [15:0] data;
    int          err_total;
    int          checked;
    int          cycles;
    int          t;
    aps_link_if lnk ();
    aps_dev #(.DATA_W(12), .PWRUP_CYC(PWRUP)) i_aps_dev (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .lnk(lnk), .i_sample(i_sample),
        .i_start_pd(i_start_pd), .o_power_down(power_down), .o_fully_up(fully_up),
        .o_tracking(tracking), .o_valid_frame(valid_frame));
    aps_host #(.HALF_CYC(4), .QUIET_CYC(aps_pkg::QUIET_CYC)) i_aps_host (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .lnk(lnk), .i_start(i_start),
        .i_edges(i_edges), .i_keep_pd(i_keep_pd), .o_ready(ready), .o_done(done),
        .o_data(data));
    aps_link_assertions i_aps_link_assertions (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
        .serial_result_out(lnk.serial_result_out), .serial_result_oe(lnk.serial_result_oe),
        .serial_result_line(lnk.serial_result_line));
    // 100 MHz reference
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // hang guard: a stuck handshake ends the run as a failure
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            $display("wrong value run length exp below %0d seen %0d", LIMIT, cycles);
            final_report();
        end
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s exp %h seen %h", name, exp, seen);
        end
    endtask
    // request taken at the edge where ready is high
    task automatic start_frame(input logic [4:0] n);
        t = 0;
        while (ready !== 1'b1 && t < 3000) begin
            @(negedge i_ref_clk);
            t++;
        end
        if (t == 3000) begin
            err_total++;
            $display("wrong value ready exp 1 seen %b", ready);
        end
        @(posedge i_ref_clk);
        i_start <= 1'b1;
        i_edges <= n;
        @(posedge i_ref_clk);
        i_start <= 1'b0;
        @(negedge i_ref_clk);
        check("ready after take", 16'h0000, 16'(ready));
    endtask
    // done is a one-cycle pulse, sampled mid-cycle; extra cycles let state settle
    task automatic wait_done;
        t = 0;
        while (done !== 1'b1 && t < 3000) begin
            @(negedge i_ref_clk);
            t++;
        end
        if (t == 3000) begin
            err_total++;
            $display("wrong value done exp 1 seen %b", done);
        end
        @(negedge i_ref_clk);
        check("done pulse", 16'h0000, 16'(done));
        repeat (2) @(negedge i_ref_clk);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        err_total = 0;
        checked = 0;
        cycles = 0;
        i_rst <= 1'b1;
        i_start_pd <= 1'b0;
        i_keep_pd <= 1'b0;
        i_start <= 1'b0;
        i_edges <= 5'h10;
        i_sample <= 12'hA5C;
        repeat (6) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        check("track in reset", 16'h0001, 16'(tracking));
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
        // timer start: release edge, counted until fully up
        t = 0;
        while (fully_up !== 1'b1 && t < 400) begin
            @(negedge i_ref_clk);
            t++;
        end
        check("power-up time ok", 16'h0001, 16'(t >= PWRUP - 3 && t <= PWRUP + 3));
        wait_done();
        check("normal after dummy", 16'h0000, 16'(power_down));
        foreach (ROWS[k]) begin
            start_frame(ROWS[k].edges);
            wait_done();
            check("power_down", 16'(ROWS[k].exp_pd), 16'(power_down));
            if (ROWS[k].chk_valid) check("valid_frame", 16'(ROWS[k].exp_valid), 16'(valid_frame));
            if (ROWS[k].chk_data) check("result", {4'h0, i_sample}, data);
            if (ROWS[k].chk_up) check("fully_up", 16'h0001, 16'(fully_up));
        end
        // wake attempt: hold while asleep, track after first clock edge
        start_frame(5'h03);
        wait_done();
        check("hold while asleep", 16'h0000, 16'(tracking));
        start_frame(5'h08);
        t = 0;
        while (lnk.sclk !== 1'b0 && t < 100) begin
            @(negedge i_ref_clk);
            t++;
        end
        repeat (5) @(negedge i_ref_clk);
        check("track after first edge", 16'h0001, 16'(tracking));
        wait_done();
        check("back asleep", 16'h0001, 16'(power_down));
        // second reset: supply start asleep, host keeps it asleep
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        i_start_pd <= 1'b1;
        i_keep_pd <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        wait_done();
        check("held asleep", 16'h0001, 16'(power_down));
        start_frame(5'h10);
        wait_done();
        check("dummy wakes", 16'h0000, 16'(power_down));
        start_frame(5'h10);
        wait_done();
        check("first valid", 16'h0001, 16'(valid_frame));
        check("first result", {4'h0, i_sample}, data);
        final_report();
    end
endmodule
